/* File: core/rmr_fifo.v */
`timescale 1ns/1ps
`default_nettype none
module rmr_fifo #(
  parameter WIDTH = 72,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             mclk,     // clock
  input  wire             srst,     // sync reset
  input  wire             ce,       // clock enable
  input  wire [WIDTH-1:0] in_data,  // write data
  input  wire             in_valid, // write valid
  output wire             in_ready, // not full
  output reg  [WIDTH-1:0] out_data, // registered head
  output reg              out_valid,// head valid
  input  wire             out_ready // consumer take
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_r;
  reg [AW-1:0]    rd_r;
  reg [AW:0]      cnt_r;
  wire            wr_en;
  wire            rd_en;
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign wr_en    = in_valid && in_ready;
  // refill output register when empty or taken
  assign rd_en    = (cnt_r != {(AW+1){1'b0}}) && (!out_valid || out_ready);
  always @(posedge mclk) begin
    if (srst) begin
      wr_r      <= {AW{1'b0}};
      rd_r      <= {AW{1'b0}};
      cnt_r     <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (wr_en) begin
        mem[wr_r] <= in_data;
        wr_r      <= wr_r + 1'b1;
      end
      if (rd_en) begin
        out_data <= mem[rd_r];
        rd_r     <= rd_r + 1'b1;
      end
      if (rd_en)
        out_valid <= 1'b1;
      else if (out_ready)
        out_valid <= 1'b0;
      if (wr_en && !rd_en)
        cnt_r <= cnt_r + 1'b1;
      else if (rd_en && !wr_en)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule // rmr_fifo
`default_nettype wire

/* File: core/rmr_map.vh */
`ifndef RMR_MAP_VH
`define RMR_MAP_VH
// message type codes
`define RMR_T_ERR_COR      5'h00
`define RMR_T_ERR_FATAL    5'h02
`define RMR_T_INTX_FIRST   5'h03
`define RMR_T_INTX_LAST    5'h0a
`define RMR_T_PM_FIRST     5'h0b
`define RMR_T_PM_LAST      5'h0e
`define RMR_T_SSPL         5'h0f
`define RMR_T_LTR          5'h10
`define RMR_T_RSVD17       5'h11
`define RMR_T_UNLOCK       5'h12
`define RMR_T_VDM0         5'h13
`define RMR_T_VDM1         5'h14
`define RMR_T_RSVD_FIRST   5'h19
// strobe lengths in cycles
`define RMR_LEN_ID         4'h2
`define RMR_LEN_PAYLOAD    4'h6
`define RMR_LEN_VDM_NODATA 4'h4
`define RMR_LEN_VDM_DATA   4'h8
// gap state cycles between messages; the strobe stays low one idle cycle more
`define RMR_GAP_CYCLES     4'h1
// fifo depth
`define RMR_FIFO_DEPTH     32
`endif

/* File: core/rmr_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "rmr_map.vh"
// Operation
// - each decodable message raises the strobe for consecutive cycles whose count follows its type.
// - parameters leave one byte per strobe cycle on the 8-bit data output.
// - the strobe drops low for at least one cycle between two messages.
// - the port only reports when its build-time enable parameter is set.
// - codes 0-2 are the error messages and 3-10 are INTA-INTD assert on odd, deassert on even.
// - codes 11-14 are the power-management messages, 15 slot power limit, 16 latency reporting.
// - 18 is unlock, 19 and 20 vendor type 0 and 1, while 17 and 25-31 are never reported.
// - every message sends requester bus number first and device/function second.
// - error, INTx, power-management and unlock messages strobe exactly two cycles.
// - slot power limit strobes six cycles with its 32-bit payload low byte first.
// - latency reporting strobes six cycles: snoop low, high, then no-snoop low, high.
// - vendor messages strobe four cycles without data and eight with data.
// - vendor messages carry vendor id low then high, then payload low byte first.
module rmr_port #(
  parameter ENABLE = 1,                // build-time port enable
  parameter DEPTH  = `RMR_FIFO_DEPTH,  // message queue depth
  parameter AW     = 5                 // queue address width
) (
  input  wire        mclk,         // 50 MHz clock
  input  wire        srst,         // sync reset, high
  input  wire        ce,           // clock enable
  input  wire        dec_valid,    // decoded message present
  output wire        dec_ready,    // queue can accept, or type reserved or port disabled
  input  wire [4:0]  dec_type,     // decoded message type
  input  wire        dec_has_data, // vendor message carries data
  input  wire [15:0] dec_req_id,   // requester bus, dev/func
  input  wire [15:0] dec_word_a,   // vendor id or snoop latency
  input  wire [31:0] dec_payload,  // payload or no-snoop in low half
  output reg         msg_strobe,   // message strobe
  output reg  [7:0]  msg_data,     // parameter byte
  output reg  [4:0]  msg_type      // message type code
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SEND = 2'h1;
  localparam ST_GAP  = 2'h2;
  localparam FW      = 70;

  reg  [1:0]    state_r;
  reg  [1:0]    state_nxt;
  reg  [3:0]    idx_r;
  reg  [3:0]    idx_nxt;
  reg  [3:0]    len_r;
  reg  [3:0]    len_nxt;
  reg  [3:0]    gap_r;
  reg  [3:0]    gap_nxt;
  reg  [FW-1:0] msg_r;
  reg  [FW-1:0] msg_nxt;
  reg  [7:0]    byte_sel;
  reg  [3:0]    len_of;
  reg           legal;
  wire [FW-1:0] q_data;
  wire          q_valid;
  wire          q_take;
  wire          q_in_valid;
  wire          q_in_ready;
  wire [4:0]    q_type;

  // reserved codes are dropped at the queue input
  always @* begin
    legal = 1'b1;
    if (dec_type == `RMR_T_RSVD17 || dec_type >= `RMR_T_RSVD_FIRST)
      legal = 1'b0;
  end

  assign q_in_valid = dec_valid && legal && (ENABLE != 0);
  assign dec_ready  = q_in_ready || !legal || (ENABLE == 0);

  rmr_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .mclk      (mclk),
    .srst      (srst),
    .ce        (ce),
    .in_data   ({dec_type, dec_has_data, dec_req_id, dec_word_a, dec_payload}),
    .in_valid  (q_in_valid),
    .in_ready  (q_in_ready),
    .out_data  (q_data),
    .out_valid (q_valid),
    .out_ready (q_take)
  );

  assign q_type = q_data[69:65];
  assign q_take = (state_r == ST_IDLE) && q_valid;

  // strobe length per type
  always @* begin
    len_of = `RMR_LEN_ID;
    if (q_type == `RMR_T_SSPL || q_type == `RMR_T_LTR)
      len_of = `RMR_LEN_PAYLOAD;
    else if (q_type == `RMR_T_VDM0 || q_type == `RMR_T_VDM1)
      len_of = q_data[64] ? `RMR_LEN_VDM_DATA : `RMR_LEN_VDM_NODATA;
  end

  // byte for the current strobe cycle; fields: req 63:48, word_a 47:32, payload 31:0
  always @* begin
    byte_sel = 8'h00;
    case (idx_r)
      4'h0: byte_sel = msg_r[63:56]; // bus number
      4'h1: byte_sel = msg_r[55:48]; // device/function
      4'h2: byte_sel = (msg_r[69:65] == `RMR_T_SSPL) ? msg_r[7:0] : msg_r[39:32];
      4'h3: byte_sel = (msg_r[69:65] == `RMR_T_SSPL) ? msg_r[15:8] : msg_r[47:40];
      4'h4: byte_sel = (msg_r[69:65] == `RMR_T_SSPL) ? msg_r[23:16] : msg_r[7:0];
      4'h5: byte_sel = (msg_r[69:65] == `RMR_T_SSPL) ? msg_r[31:24] : msg_r[15:8];
      4'h6: byte_sel = msg_r[23:16];
      4'h7: byte_sel = msg_r[31:24];
      default: byte_sel = 8'h00;
    endcase
  end

  always @* begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    len_nxt   = len_r;
    gap_nxt   = gap_r;
    msg_nxt   = msg_r;
    case (state_r)
      ST_IDLE: begin
        if (q_valid) begin
          msg_nxt   = q_data;
          len_nxt   = len_of;
          idx_nxt   = 4'h0;
          state_nxt = ST_SEND;
        end
      end
      ST_SEND: begin
        if (idx_r == len_r - 4'h1) begin
          gap_nxt   = `RMR_GAP_CYCLES;
          state_nxt = ST_GAP;
        end else begin
          idx_nxt = idx_r + 4'h1;
        end
      end
      ST_GAP: begin
        if (gap_r <= 4'h1)
          state_nxt = ST_IDLE;
        else
          gap_nxt = gap_r - 4'h1;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      idx_r   <= 4'h0;
      len_r   <= 4'h0;
      gap_r   <= 4'h0;
      msg_r   <= {FW{1'b0}};
    end else if (ce) begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      len_r   <= len_nxt;
      gap_r   <= gap_nxt;
      msg_r   <= msg_nxt;
    end
  end

  // registered port outputs, one cycle behind the state
  always @(posedge mclk) begin
    if (srst) begin
      msg_strobe <= 1'b0;
      msg_data   <= 8'h00;
      msg_type   <= 5'h00;
    end else if (ce) begin
      msg_strobe <= (state_r == ST_SEND);
      msg_data   <= (state_r == ST_SEND) ? byte_sel : 8'h00;
      msg_type   <= (state_r == ST_SEND) ? msg_r[69:65] : 5'h00;
    end
  end
endmodule // rmr_port
`default_nettype wire

/* File: sim/rmr_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module rmr_port_chk (
  input wire logic       mclk,       // clock
  input wire logic       srst,       // sync reset
  input wire logic       ce,         // clock enable, low stretches a message
  input wire logic       msg_strobe, // strobe
  input wire logic [7:0] msg_data,   // byte
  input wire logic [4:0] msg_type    // type
);
  wire       s = msg_strobe;
  wire [4:0] t = msg_type;
  default clocking @(posedge mclk); endclocking
  // a frozen port holds its strobe, so length checks stand aside while ce is low
  default disable iff (srst || !ce);
  a_idle_zero: assert property (!s |-> msg_data == 8'h00 && t == 5'h00)
    else $error("idle not zero");
  a_type_steady: assert property (s && $past(s) |-> $stable(t))
    else $error("type moved");
  a_no_reserved: assert property (s |-> t != 5'h11 && t < 5'h19)
    else $error("reserved type");
  a_run_bound: assert property (s [*8] |=> !s)
    else $error("no gap");
  a_id_two: assert property ($rose(s) && (t < 5'h0f || t == 5'h12 || t > 5'h14) |-> s [*2] ##1 !s)
    else $error("bad short len");
  a_six_len: assert property ($rose(s) && (t == 5'h0f || t == 5'h10) |-> s [*6] ##1 !s)
    else $error("bad six len");
  a_vdm_len: assert property ($rose(s) && (t == 5'h13 || t == 5'h14) |-> (s [*4] ##1 !s) or (s [*8] ##1 !s))
    else $error("bad vendor len");
  a_min_two: assert property ($rose(s) |=> s)
    else $error("short strobe");
  c_sspl: cover property ($rose(s) && t == 5'h0f);
  c_vdm: cover property ($rose(s) && t == 5'h14 ##0 s [*8]);
  c_gap: cover property ($fell(s) ##1 $rose(s));
endmodule // rmr_port_chk
bind rmr_port rmr_port_chk i_rmr_port_chk (.mclk, .srst, .ce, .msg_strobe, .msg_data, .msg_type);
`default_nettype wire

/* File: sim/rmr_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rmr_port_tb;
  logic        mclk, srst, ce, dec_valid, dec_has_data, full_seen, off_seen;
  logic [4:0]  dec_type;
  logic [15:0] dec_req_id, dec_word_a;
  logic [31:0] dec_payload;
  wire         dec_ready, msg_strobe, off_strobe;
  wire  [7:0]  msg_data;
  wire  [4:0]  msg_type;
  logic [7:0]  exp_b[$];
  logic [4:0]  exp_t[$];
  int          exp_l[$];
  int          n_mismatch = 0, n_tests = 0, i, k, n_hi;
  logic [9:0]  rows [0:5] = '{{5'h0f, 1'b0, 4'h6}, {5'h10, 1'b0, 4'h6}, {5'h13, 1'b0, 4'h4},
                              {5'h14, 1'b1, 4'h8}, {5'h12, 1'b0, 4'h2}, {5'h04, 1'b1, 4'h2}};
  rmr_port i_rmr_port (.mclk, .srst, .ce, .dec_valid, .dec_ready, .dec_type, .dec_has_data,
    .dec_req_id, .dec_word_a, .dec_payload, .msg_strobe, .msg_data, .msg_type);
  rmr_port #(.ENABLE(0)) i_rmr_port_off (.mclk, .srst, .ce, .dec_valid, .dec_ready(), .dec_type,
    .dec_has_data, .dec_req_id, .dec_word_a, .dec_payload, .msg_strobe(off_strobe), .msg_data(), .msg_type());
  rmr_user_model i_rmr_user_model (.mclk, .msg_strobe, .msg_data, .msg_type);
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wait_strobe;
    for (k = 0; k < 20 && msg_strobe !== 1'b1; k++) @(negedge mclk);
    if (msg_strobe !== 1'b1) begin
      n_mismatch++;
      report_and_stop;
    end
  endtask
  task send(input logic [4:0] t, input logic hd, input int len);
    logic [15:0] id;
    logic [31:0] p;
    id = {3'h5, t, ~t, 3'h2};
    p = {id, ~id} ^ 32'h0f1e2d3c;
    dec_type <= t;
    dec_has_data <= hd;
    dec_req_id <= id;
    dec_word_a <= ~id;
    dec_payload <= p;
    dec_valid <= 1'b1;
    if (t != 5'h11 && t < 5'h19) begin
      exp_t.push_back(t);
      exp_l.push_back(len);
      if (t < 5'h15 || t > 5'h18) exp_b = {exp_b, id[15:8], id[7:0]};
      if (t == 5'h10 || t == 5'h13 || t == 5'h14) exp_b = {exp_b, ~id[7:0], ~id[15:8]};
      if (t == 5'h10) exp_b = {exp_b, p[7:0], p[15:8]};
      if (t == 5'h0f || (t > 5'h12 && t < 5'h15 && hd)) exp_b = {exp_b, p[7:0], p[15:8], p[23:16], p[31:24]};
    end
    k = 0;
    do begin
      @(negedge mclk);
      k++;
      if (dec_ready === 1'b0) full_seen = 1'b1;
    end while (dec_ready !== 1'b1 && k < 400);
    if (dec_ready !== 1'b1) begin
      n_mismatch++;
      report_and_stop;
    end
    @(posedge mclk);
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) if (off_strobe === 1'b1) off_seen <= 1'b1;
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    dec_valid = 1'b0;
    dec_type = 5'h00;
    dec_has_data = 1'b0;
    dec_req_id = 16'h0000;
    dec_word_a = 16'h0000;
    dec_payload = 32'h00000000;
    full_seen = 1'b0;
    off_seen = 1'b0;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    for (i = 0; i < 6; i++) send(rows[i][9:5], rows[i][4], rows[i][3:0]);
    for (i = 0; i < 32; i++) send(i[4:0], i[0], (i == 15 || i == 16) ? 6 : (i == 19) ? 8 : (i == 20) ? 4 : 2);
    for (i = 0; i < 40; i++) send(5'h14, 1'b1, 8);
    dec_valid <= 1'b0;
    for (k = 0; k < 3000 && i_rmr_user_model.len.size() < exp_l.size(); k++) @(posedge mclk);
    if (i_rmr_user_model.len.size() < exp_l.size()) begin
      n_mismatch++;
      report_and_stop;
    end
    repeat (4) @(posedge mclk);
    chk("count", i_rmr_user_model.len.size(), exp_l.size());
    for (i = 0; i < exp_l.size() && i < i_rmr_user_model.len.size(); i++) begin
      chk("len", i_rmr_user_model.len[i], exp_l[i]);
      chk("type", i_rmr_user_model.typ[i], exp_t[i]);
    end
    chk("nbytes", i_rmr_user_model.got.size(), exp_b.size());
    for (i = 0; i < exp_b.size() && i < i_rmr_user_model.got.size(); i++) chk("byte", i_rmr_user_model.got[i], exp_b[i]);
    chk("full", full_seen, 1'b1);
    chk("disabled", off_seen, 1'b0);
    // ce low freezes a message in mid-strobe
    send(5'h0f, 1'b0, 6);
    dec_valid <= 1'b0;
    wait_strobe;
    chk("freeze first", msg_data, dec_req_id[15:8]);
    @(posedge mclk);
    ce <= 1'b0;
    repeat (3) @(negedge mclk);
    chk("freeze strobe", msg_strobe, 1'b1);
    chk("freeze data", msg_data, dec_req_id[7:0]);
    @(posedge mclk);
    ce <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk("resume data", msg_data, dec_payload[7:0]);
    // reset in mid-message clears outputs and queue
    repeat (8) @(posedge mclk);
    send(5'h14, 1'b1, 8);
    send(5'h13, 1'b1, 8);
    dec_valid <= 1'b0;
    wait_strobe;
    @(posedge mclk);
    srst <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk("reset strobe", msg_strobe, 1'b0);
    chk("reset type", msg_type, 5'h00);
    chk("reset data", msg_data, 8'h00);
    @(posedge mclk);
    srst <= 1'b0;
    n_hi = 0;
    repeat (20) begin
      @(negedge mclk);
      if (msg_strobe !== 1'b0) n_hi++;
    end
    chk("flushed", n_hi, 0);
    @(posedge mclk);
    send(5'h0b, 1'b0, 2);
    dec_valid <= 1'b0;
    wait_strobe;
    chk("after reset type", msg_type, 5'h0b);
    chk("after reset bus", msg_data, dec_req_id[15:8]);
    @(negedge mclk);
    chk("after reset devfn", msg_data, dec_req_id[7:0]);
    @(negedge mclk);
    chk("after reset end", msg_strobe, 1'b0);
    report_and_stop;
  end
endmodule // rmr_port_tb
`default_nettype wire

/* File: sim/rmr_user_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rmr_user_model (
  input wire logic       mclk,       // clock
  input wire logic       msg_strobe, // strobe
  input wire logic [7:0] msg_data,   // byte
  input wire logic [4:0] msg_type    // type
);
  logic [7:0] got[$];
  logic [4:0] typ[$];
  int         len[$];
  int         run = 0;
  always @(posedge mclk) begin
    if (msg_strobe === 1'b1) begin
      if (run == 0) typ.push_back(msg_type);
      if (msg_type < 5'h15 || msg_type > 5'h18) got.push_back(msg_data);
      run++;
    end else if (run != 0) begin
      len.push_back(run);
      run = 0;
    end
  end
endmodule // rmr_user_model
`default_nettype wire
